// ===== rtl/codec_clock_defines.vh
// Constants for the codec clock and reset generator: register offsets,
// field positions, reset values and counts.
// Assumes inclusion by bare name from the design and testbench files.
`ifndef CODEC_CLOCK_DEFINES_VH
`define CODEC_CLOCK_DEFINES_VH

// ==========================================================
// Register byte offsets
`define OFS_CLK_CTRL 8'h00
`define OFS_PLL_CTRL 8'h04
`define OFS_CLK_TOP 8'h08
`define OFS_FRAME_DIV 8'h0C
`define OFS_STATUS 8'h10

// ==========================================================
// Clock control fields
`define CC_ASYNC_BIT 0
`define CC_RATIO_LSB 1
`define CC_RATIO_MSB 2
`define CC_RATE_LSB 3
`define CC_RATE_MSB 5
`define CC_SLAVE_BIT 6
`define CC_RUN_BIT 7
`define CC_WIDTH 8
`define CC_RESET 8'h00

// Ratio codes and their master clocks per frame
`define RATIO_256 2'h0
`define RATIO_384 2'h1
`define RATIO_512 2'h2
`define DIV_256 13'h0100
`define DIV_384 13'h0180
`define DIV_512 13'h0200

// Rate codes: 8, 11.025, 16, 22.5, 32, 44.1, 48, 96 kHz
`define RATE_96K 3'h7

// ==========================================================
// PLL control fields
`define PLL_FRAC_LSB 0
`define PLL_FRAC_MSB 10
`define PLL_INT_LSB 11
`define PLL_INT_MSB 15
`define PLL_INT_RESET 5'h00
`define PLL_FRAC_RESET 11'h000
`define HALVE_BIT 0

// ==========================================================
// Frame divider for the PLL root and status bits
`define FDIV_WIDTH 13
`define FDIV_RESET 13'h1000
`define ST_RELEASED_BIT 0
`define ST_PLL_ON_BIT 1
`define ST_ROOT_PLL_BIT 2
`define ST_PENDING_BIT 3
`define ST_CFG_ERR_BIT 4

// ==========================================================
// Counts
`define RESET_MCLK_CYCLES 4'h8
`define BIT_SHIFT 7

// ==========================================================
// Bus responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ===== rtl/pin_sync_edge.v
// Two-stage synchroniser for a pin with a rising-edge strobe.
// Assumes the pin toggles well below half the aclk rate.
`timescale 1ns/10ps
`default_nettype none

module pin_sync_edge
(
	input wire aclk, // System clock
	input wire aresetn, // Synchronous reset, active low
	input wire pin_in, // Asynchronous pin
	output reg level_r, // Synchronised level
	output reg rise_r // One-cycle pulse on rising edge
);

reg meta_r;
reg sync_r;

// ==========================================================
// Crossing; meta_r feeds only sync_r
always @(posedge aclk)
begin
	if (!aresetn)
	begin
		meta_r <= 1'b0;
		sync_r <= 1'b0;
		level_r <= 1'b0;
		rise_r <= 1'b0;
	end
	else
	begin
		meta_r <= pin_in;
		sync_r <= meta_r;
		level_r <= sync_r;
		rise_r <= sync_r & ~level_r;
	end
end

endmodule // pin_sync_edge

`default_nettype wire

// ===== rtl/codec_clock_and_reset_gen.v
// Codec clock generator and internal reset release, AXI4-Lite slave.
// Assumes pll_tick is a same-clock strobe from the PLL model and that
// the master clock pin and supply good pin are asynchronous.
//
// Our own choices: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
`include "codec_clock_defines.vh"

module codec_clock_and_reset_gen
(
	input wire aclk, // System clock, 250 MHz
	input wire aresetn, // Synchronous reset, active low
	input wire system_master_clock_pin, // Master clock pin
	input wire supplies_good_pin, // High when all rails are up
	input wire pll_tick, // One tick per PLL output cycle
	input wire [7:0] s_axi_awaddr, // Write address
	input wire s_axi_awvalid, // Write address valid
	output reg s_axi_awready, // Write address ready
	input wire [31:0] s_axi_wdata, // Write data
	input wire [3:0] s_axi_wstrb, // Write byte strobes
	input wire s_axi_wvalid, // Write data valid
	output reg s_axi_wready, // Write data ready
	output reg [1:0] s_axi_bresp, // Write response
	output reg s_axi_bvalid, // Write response valid
	input wire s_axi_bready, // Write response ready
	input wire [7:0] s_axi_araddr, // Read address
	input wire s_axi_arvalid, // Read address valid
	output reg s_axi_arready, // Read address ready
	output reg [31:0] s_axi_rdata, // Read data
	output reg [1:0] s_axi_rresp, // Read response
	output reg s_axi_rvalid, // Read data valid
	input wire s_axi_rready, // Read data ready
	output reg internal_reset_n_r, // Internal reset, active low
	output reg pll_power_en_r, // PLL power enable
	output reg [4:0] pll_integer_divider_r, // PLL integer divider
	output reg [10:0] pll_fraction_divider_r, // PLL fraction divider
	output reg input_halving_select_r, // Halve PLL input
	output reg bit_clock_r, // Serial bit clock, 64 per frame
	output reg frame_clock_r, // Serial frame clock
	output reg root_is_pll_r // Audio root currently the PLL
);

// ==========================================================
// Declarations
wire mclk_rise;
wire supply_level;
reg [3:0] rel_cnt_r;
reg released_r;
reg [`CC_WIDTH-1:0] clk_ctrl_r;
reg [`FDIV_WIDTH-1:0] frame_div_r;
reg cfg_err_r;
reg aw_hold_r;
reg w_hold_r;
reg [7:0] aw_addr_r;
reg [31:0] w_data_r;
reg [3:0] w_strb_r;
reg [31:0] wr_val;
reg [`CC_WIDTH-1:0] cc_nxt;
reg cc_bad;
reg [31:0] rd_val;
reg rd_ok;
reg [`FDIV_WIDTH-1:0] tick_cnt_r;
reg [`FDIV_WIDTH-1:0] bit_cnt_r;
reg [`FDIV_WIDTH-1:0] div_now;
wire [`FDIV_WIDTH-1:0] bit_half;
wire root_tick;
wire running;
wire idle;
wire err_set;
wire err_clr;

// Byte-lane merge of a write into an old word
function [31:0] merge;
	input [31:0] old_v;
	input [31:0] new_v;
	input [3:0] strb;
	integer i;
	begin
		merge = old_v;
		for (i = 0; i < 4; i = i + 1)
			if (strb[i])
				merge[i*8 +: 8] = new_v[i*8 +: 8];
	end
endfunction

// ==========================================================
// Pin crossings
pin_sync_edge u_mclk_sync
(
	.aclk(aclk),
	.aresetn(aresetn),
	.pin_in(system_master_clock_pin),
	.level_r(),
	.rise_r(mclk_rise)
);

pin_sync_edge u_supply_sync
(
	.aclk(aclk),
	.aresetn(aresetn),
	.pin_in(supplies_good_pin),
	.level_r(supply_level),
	.rise_r()
);

// ==========================================================
// Internal reset: restarts whenever a rail drops
always @(posedge aclk)
begin
	if (!aresetn)
	begin
		rel_cnt_r <= 4'h0;
		released_r <= 1'b0;
		internal_reset_n_r <= 1'b0;
	end
	else
	begin
		if (!supply_level)
		begin
			rel_cnt_r <= 4'h0;
			released_r <= 1'b0;
		end
		else if (!released_r && mclk_rise)
		begin
			if (rel_cnt_r == `RESET_MCLK_CYCLES - 4'h1)
				released_r <= 1'b1;
			rel_cnt_r <= rel_cnt_r + 4'h1;
		end
		internal_reset_n_r <= released_r && supply_level;
	end
end

// ==========================================================
// Write decode and legality of a clock control value
always @*
begin
	wr_val = 32'h0000_0000;
	cc_bad = 1'b0;
	case (aw_addr_r)
	`OFS_CLK_CTRL:
		wr_val = merge({24'h00_0000, clk_ctrl_r}, w_data_r, w_strb_r);
	`OFS_PLL_CTRL:
		wr_val = merge({16'h0000, pll_integer_divider_r, pll_fraction_divider_r},
			w_data_r, w_strb_r);
	`OFS_CLK_TOP:
		wr_val = merge({31'h0000_0000, input_halving_select_r}, w_data_r, w_strb_r);
	`OFS_FRAME_DIV:
		wr_val = merge({19'h0_0000, frame_div_r}, w_data_r, w_strb_r);
	`OFS_STATUS:
		wr_val = merge(32'h0000_0000, w_data_r, w_strb_r);
	default:
		wr_val = 32'h0000_0000;
	endcase
	cc_nxt = wr_val[`CC_WIDTH-1:0];
	// Ratio code 3 does not exist
	if (cc_nxt[`CC_RATIO_MSB:`CC_RATIO_LSB] == 2'h3)
		cc_bad = 1'b1;
	if (cc_nxt[`CC_RATE_MSB:`CC_RATE_LSB] == `RATE_96K
		&& cc_nxt[`CC_RATIO_MSB:`CC_RATIO_LSB] != `RATIO_256)
		cc_bad = 1'b1;
	if (cc_nxt[`CC_ASYNC_BIT] && cc_nxt[`CC_SLAVE_BIT])
		cc_bad = 1'b1;
end

// Config error flag: set wins over a write-one clear
assign err_set = aw_hold_r && w_hold_r && !s_axi_bvalid && released_r
	&& aw_addr_r == `OFS_CLK_CTRL && cc_bad;
assign err_clr = aw_hold_r && w_hold_r && !s_axi_bvalid && released_r
	&& aw_addr_r == `OFS_STATUS && wr_val[`ST_CFG_ERR_BIT];

// ==========================================================
// Write channel and register storage
always @(posedge aclk)
begin
	if (!aresetn)
	begin
		s_axi_awready <= 1'b0;
		s_axi_wready <= 1'b0;
		s_axi_bvalid <= 1'b0;
		s_axi_bresp <= `RESP_OKAY;
		aw_hold_r <= 1'b0;
		w_hold_r <= 1'b0;
		aw_addr_r <= 8'h00;
		w_data_r <= 32'h0000_0000;
		w_strb_r <= 4'h0;
		clk_ctrl_r <= `CC_RESET;
		pll_integer_divider_r <= `PLL_INT_RESET;
		pll_fraction_divider_r <= `PLL_FRAC_RESET;
		input_halving_select_r <= 1'b0;
		frame_div_r <= `FDIV_RESET;
		cfg_err_r <= 1'b0;
	end
	else
	begin
		if (!aw_hold_r && !s_axi_awready && !s_axi_bvalid)
			s_axi_awready <= 1'b1;
		if (!w_hold_r && !s_axi_wready && !s_axi_bvalid)
			s_axi_wready <= 1'b1;
		if (s_axi_awvalid && s_axi_awready)
		begin
			aw_hold_r <= 1'b1;
			aw_addr_r <= {s_axi_awaddr[7:2], 2'h0};
			s_axi_awready <= 1'b0;
		end
		if (s_axi_wvalid && s_axi_wready)
		begin
			w_hold_r <= 1'b1;
			w_data_r <= s_axi_wdata;
			w_strb_r <= s_axi_wstrb;
			s_axi_wready <= 1'b0;
		end
		if (aw_hold_r && w_hold_r && !s_axi_bvalid)
		begin
			aw_hold_r <= 1'b0;
			w_hold_r <= 1'b0;
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= `RESP_OKAY;
			// Nothing is stored before the internal reset releases
			if (!released_r)
				s_axi_bresp <= `RESP_SLVERR;
			else
				case (aw_addr_r)
				`OFS_CLK_CTRL:
					if (cc_bad)
						s_axi_bresp <= `RESP_SLVERR;
					else
						clk_ctrl_r <= cc_nxt;
				`OFS_PLL_CTRL:
				begin
					pll_integer_divider_r <= wr_val[`PLL_INT_MSB:`PLL_INT_LSB];
					pll_fraction_divider_r <= wr_val[`PLL_FRAC_MSB:`PLL_FRAC_LSB];
				end
				`OFS_CLK_TOP:
					input_halving_select_r <= wr_val[`HALVE_BIT];
				`OFS_FRAME_DIV:
					frame_div_r <= wr_val[`FDIV_WIDTH-1:0];
				`OFS_STATUS:
					s_axi_bresp <= `RESP_OKAY;
				default:
					s_axi_bresp <= `RESP_SLVERR;
				endcase
		end
		if (s_axi_bvalid && s_axi_bready)
			s_axi_bvalid <= 1'b0;
		if (err_set)
			cfg_err_r <= 1'b1;
		else if (err_clr)
			cfg_err_r <= 1'b0;
	end
end

// ==========================================================
// Read decode
always @*
begin
	rd_val = 32'h0000_0000;
	rd_ok = 1'b1;
	case ({s_axi_araddr[7:2], 2'h0})
	`OFS_CLK_CTRL:
		rd_val = {24'h00_0000, clk_ctrl_r};
	`OFS_PLL_CTRL:
		rd_val = {16'h0000, pll_integer_divider_r, pll_fraction_divider_r};
	`OFS_CLK_TOP:
		rd_val = {31'h0000_0000, input_halving_select_r};
	`OFS_FRAME_DIV:
		rd_val = {19'h0_0000, frame_div_r};
	`OFS_STATUS:
	begin
		rd_val[`ST_RELEASED_BIT] = released_r;
		rd_val[`ST_PLL_ON_BIT] = pll_power_en_r;
		rd_val[`ST_ROOT_PLL_BIT] = root_is_pll_r;
		rd_val[`ST_PENDING_BIT] = root_is_pll_r != clk_ctrl_r[`CC_ASYNC_BIT];
		rd_val[`ST_CFG_ERR_BIT] = cfg_err_r;
	end
	default:
		rd_ok = 1'b0;
	endcase
end

// Read channel; one cycle from address to data
always @(posedge aclk)
begin
	if (!aresetn)
	begin
		s_axi_arready <= 1'b0;
		s_axi_rvalid <= 1'b0;
		s_axi_rdata <= 32'h0000_0000;
		s_axi_rresp <= `RESP_OKAY;
	end
	else
	begin
		if (!s_axi_arready && !s_axi_rvalid)
			s_axi_arready <= 1'b1;
		if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_val;
			s_axi_rresp <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
		end
		if (s_axi_rvalid && s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end
end

// ==========================================================
// Root selection and frame length
assign running = clk_ctrl_r[`CC_RUN_BIT] && internal_reset_n_r;
// Idle also needs both clock outputs low, so a switch never clips a phase
assign idle = !running && tick_cnt_r == {`FDIV_WIDTH{1'b0}}
	&& !bit_clock_r && !frame_clock_r;
// Synchronous root counts master clock edges locked to the frame
assign root_tick = root_is_pll_r ? pll_tick : mclk_rise;

always @*
begin
	div_now = `DIV_256;
	if (root_is_pll_r)
		div_now = frame_div_r;
	else
		case (clk_ctrl_r[`CC_RATIO_MSB:`CC_RATIO_LSB])
		`RATIO_256:
			div_now = `DIV_256;
		`RATIO_384:
			div_now = `DIV_384;
		`RATIO_512:
			div_now = `DIV_512;
		default:
			div_now = `DIV_256;
		endcase
end

// 64 bit clocks per frame; PLL frame length should be a multiple of 128
assign bit_half = div_now >> `BIT_SHIFT;

// ==========================================================
// Audio dividers and glitch-free root switch
always @(posedge aclk)
begin
	if (!aresetn)
	begin
		root_is_pll_r <= 1'b0;
		pll_power_en_r <= 1'b0;
		tick_cnt_r <= {`FDIV_WIDTH{1'b0}};
		bit_cnt_r <= {`FDIV_WIDTH{1'b0}};
		bit_clock_r <= 1'b0;
		frame_clock_r <= 1'b0;
	end
	else
	begin
		// PLL stays off unless asynchronous mode is asked for or in use
		pll_power_en_r <= clk_ctrl_r[`CC_ASYNC_BIT] || root_is_pll_r;
		// Changing root mid-frame would clip a clock phase
		if (idle)
			root_is_pll_r <= clk_ctrl_r[`CC_ASYNC_BIT];
		if (!running)
		begin
			tick_cnt_r <= {`FDIV_WIDTH{1'b0}};
			bit_cnt_r <= {`FDIV_WIDTH{1'b0}};
			bit_clock_r <= 1'b0;
			frame_clock_r <= 1'b0;
		end
		else if (root_tick)
		begin
			// Integer division of the root into frame and bit clocks
			if (tick_cnt_r >= div_now - {{(`FDIV_WIDTH-1){1'b0}}, 1'b1})
			begin
				tick_cnt_r <= {`FDIV_WIDTH{1'b0}};
				frame_clock_r <= 1'b0;
			end
			else
			begin
				tick_cnt_r <= tick_cnt_r + {{(`FDIV_WIDTH-1){1'b0}}, 1'b1};
				frame_clock_r <= (tick_cnt_r + {{(`FDIV_WIDTH-1){1'b0}}, 1'b1})
					>= (div_now >> 1);
			end
			if (bit_cnt_r >= bit_half - {{(`FDIV_WIDTH-1){1'b0}}, 1'b1})
			begin
				bit_cnt_r <= {`FDIV_WIDTH{1'b0}};
				bit_clock_r <= ~bit_clock_r;
			end
			else
				bit_cnt_r <= bit_cnt_r + {{(`FDIV_WIDTH-1){1'b0}}, 1'b1};
		end
	end
end

endmodule // codec_clock_and_reset_gen

`default_nettype wire

// ===== testbench/codec_clock_gen_monitor.sv
// Port checker for the codec clock and reset generator.
// Assumes the master clock pin toggles well below half the aclk rate.
`timescale 1ns/10ps
`default_nettype none
`include "codec_clock_defines.vh"
module codec_clock_gen_monitor
(
	input wire logic aclk, // System clock
	input wire logic aresetn, // Reset, active low
	input wire logic system_master_clock_pin, // Master clock
	input wire logic supplies_good_pin, // Rails up
	input wire logic s_axi_awready, // Write address ready
	input wire logic s_axi_arvalid, // Read address valid
	input wire logic s_axi_arready, // Read address ready
	input wire logic [1:0] s_axi_bresp, // Write response
	input wire logic s_axi_bvalid, // Write response valid
	input wire logic s_axi_bready, // Write response ready
	input wire logic [31:0] s_axi_rdata, // Read data
	input wire logic s_axi_rvalid, // Read data valid
	input wire logic s_axi_rready, // Read data ready
	input wire logic internal_reset_n_r, // Internal reset
	input wire logic pll_power_en_r, // PLL power
	input wire logic bit_clock_r, // Bit clock
	input wire logic frame_clock_r, // Frame clock
	input wire logic root_is_pll_r // Root select
);
	logic mc_d;
	logic [3:0] mc_cnt;
	// ==========================================
	// Raw master clock rises since rails up; counts ahead of the synchroniser
	always_ff @(posedge aclk)
	begin
		mc_d <= system_master_clock_pin;
		if (!aresetn || !supplies_good_pin)
			mc_cnt <= 4'h0;
		else if (system_master_clock_pin && !mc_d && mc_cnt != 4'hF)
			mc_cnt <= mc_cnt + 4'h1;
	end
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_release_count: assert property ($rose(internal_reset_n_r) |-> mc_cnt >= 4'h8)
		else $error("internal reset released early");
	a_early_write_err: assert property ($rose(s_axi_bvalid) && !internal_reset_n_r |-> s_axi_bresp == `RESP_SLVERR)
		else $error("write before release not refused");
	a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read not answered");
	a_write_busy: assert property (s_axi_bvalid |-> !s_axi_awready)
		else $error("write address taken while busy");
	a_pll_root_power: assert property (root_is_pll_r |=> pll_power_en_r)
		else $error("PLL root without power");
	a_root_idle_switch: assert property ($changed(root_is_pll_r) |-> !$past(frame_clock_r) && !$past(bit_clock_r))
		else $error("root switched while clocks active");
endmodule // codec_clock_gen_monitor
bind codec_clock_and_reset_gen codec_clock_gen_monitor u_mon (.*);
`default_nettype wire

// ===== testbench/master_clock_source.sv
// Master clock source and rail monitor beside the codec clock block.
// Assumes aclk at 250 MHz; master clock at 25 MHz runs free.
`timescale 1ns/10ps
`default_nettype none
module master_clock_source
(
	input wire logic aclk, // System clock
	input wire logic supply_req, // Bench asks for rails up
	output var logic system_master_clock_pin, // Master clock
	output var logic supplies_good_pin, // Rails up
	output var logic pll_tick // PLL output strobe
);
	logic [1:0] div_r = 2'h0;
	// ==========================================
	// Free-running 25 MHz, inside the 8 to 27 MHz range and fixed per frame
	initial
	begin
		system_master_clock_pin = 1'b0;
		supplies_good_pin = 1'b0;
		pll_tick = 1'b0;
		forever #20 system_master_clock_pin = ~system_master_clock_pin;
	end
	// PLL output modelled as one strobe every four cycles
	always @(posedge aclk)
	begin
		div_r <= div_r + 2'h1;
		pll_tick <= (div_r == 2'h3);
		supplies_good_pin <= supply_req;
	end
endmodule // master_clock_source
`default_nettype wire

// ===== testbench/codec_clock_and_reset_gen_bench.sv
// Self-checking bench for the codec clock and reset generator.
// Assumes the checker is bound and the clock source model beside it.
`timescale 1ns/10ps
`default_nettype none
`include "codec_clock_defines.vh"
module codec_clock_and_reset_gen_bench;
	logic aclk = 1'b0, aresetn = 1'b0, supply_req = 1'b0, mclk, sgood, ptick;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [31:0] wdata = 32'h0, rdata;
	logic [3:0] wstrb = 4'hF;
	logic awready, wready, bvalid, arready, rvalid, irst_n, ppwr, halve, bclk, fclk, root;
	logic [1:0] bresp, rresp;
	logic [4:0] pint;
	logic [10:0] pfrac;
	logic [31:0] mdl [0:3] = '{32'h0, 32'h0, 32'h0, 32'h1000};
	logic [31:0] wmask [0:3] = '{32'hFF, 32'hFFFF, 32'h1, 32'h1FFF};
	logic err_m = 1'b0, rel_m = 1'b0, mclk_d = 1'b0, bc_d = 1'b0, fc_d = 1'b0;
	int n_errors = 0, total_checks = 0, cycles = 0, n_rises = 0;
	int tbl [0:2] = '{256, 384, 512};
	logic [31:0] d;
	master_clock_source src (.aclk(aclk), .supply_req(supply_req),
		.system_master_clock_pin(mclk), .supplies_good_pin(sgood), .pll_tick(ptick));
	codec_clock_and_reset_gen dut (.aclk(aclk), .aresetn(aresetn),
		.system_master_clock_pin(mclk), .supplies_good_pin(sgood), .pll_tick(ptick),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.internal_reset_n_r(irst_n), .pll_power_en_r(ppwr), .pll_integer_divider_r(pint),
		.pll_fraction_divider_r(pfrac), .input_halving_select_r(halve),
		.bit_clock_r(bclk), .frame_clock_r(fclk), .root_is_pll_r(root));
	// ==========================================
	// Clock, edge history and hang guard
	initial
	begin
		forever #2 aclk = ~aclk;
	end
	always @(posedge aclk)
	begin
		mclk_d <= mclk;
		bc_d <= bclk;
		fc_d <= fclk;
		// Master clock rises seen while the rails are up
		if (sgood && mclk && !mclk_d) n_rises++;
		cycles++;
		if (cycles == 60000)
		begin
			n_errors++;
			test_done();
		end
	end
	task check_word(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			n_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task check_resp(input logic [1:0] got, input logic [1:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			n_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	function logic cc_ok(input logic [31:0] v);
		return v[2:1] != 2'h3 && !(v[5:3] == `RATE_96K && v[2:1] != 2'h0) && !(v[0] && v[6]);
	endfunction
	// ==========================================
	// Bus master; model updated from the documented refusals
	task wr(input logic [7:0] a, input logic [31:0] v);
		logic ok;
		ok = rel_m && a < 8'h14 && (a != 8'h00 || cc_ok(v));
		@(posedge aclk);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
		end
		while (bvalid !== 1'b1);
		bready <= 1'b0;
		check_resp(bresp, ok ? `RESP_OKAY : `RESP_SLVERR);
		if (rel_m && a == 8'h00 && !ok) err_m = 1'b1;
		else if (ok && a == 8'h10 && v[4]) err_m = 1'b0;
		else if (ok && a < 8'h10) mdl[a[3:2]] = v & wmask[a[3:2]];
	endtask
	task rd(input logic [7:0] a);
		logic [31:0] e;
		// Status reads happen while the root is the master clock: bits 3:1 stay low
		e = a < 8'h10 ? mdl[a[3:2]] : a == 8'h10 ? {27'h0, err_m, 3'h0, rel_m} : 32'h0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'b0;
		end
		while (rvalid !== 1'b1);
		rready <= 1'b0;
		check_word(rdata, e);
		check_resp(rresp, a < 8'h14 ? `RESP_OKAY : `RESP_SLVERR);
	endtask
	// Ticks and bit clock rises over one whole frame
	task measure(input logic use_pll, input int exp_t);
		int t, b;
		t = 0;
		b = 0;
		do @(posedge aclk); while (!(fclk && !fc_d));
		do
		begin
			@(posedge aclk);
			t += use_pll ? int'(ptick) : int'(mclk && !mclk_d);
			b += int'(bclk && !bc_d);
		end
		while (!(fclk && !fc_d));
		check_word(t, exp_t);
		check_word(b, 64);
	endtask
	task test_done();
		$display("checks %0d mismatches %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// ==========================================
	// Main sequence
	initial
	begin
		void'($urandom(32'h24DD884B));
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		for (int i = 0; i < 5; i++) rd(8'(i * 4));
		wr(8'h0C, 32'h100);
		rd(8'h0C);
		$display("test reset values done");
		supply_req <= 1'b1;
		while (irst_n !== 1'b1) @(posedge aclk);
		check_word(n_rises, 32'h8);
		rel_m = 1'b1;
		wr(8'h0C, 32'h100);
		$display("test release done");
		for (int i = 0; i < 8; i++) wr(8'h00, 32'(i) << 3);
		wr(8'h00, 32'h3A);
		wr(8'h00, 32'h3C);
		wr(8'h00, 32'h06);
		wr(8'h00, 32'h41);
		rd(8'h00);
		rd(8'h10);
		wr(8'h10, 32'h10);
		rd(8'h10);
		wr(8'h14, 32'h1);
		rd(8'h14);
		$display("test modes done");
		wr(8'h08, 32'h0);
		wr(8'h04, ((196608 / 12000) << 11) | ((196608 % 12000) * 2048 / 12000));
		@(posedge aclk);
		check_word({pint, pfrac, 15'h0, halve}, {5'd16, 11'd786, 16'h0});
		d = $urandom & 32'hFFFF;
		wr(8'h04, d);
		wr(8'h08, 32'h1);
		rd(8'h04);
		@(posedge aclk);
		check_word({pint, pfrac, 15'h0, halve}, {d[15:0], 16'h1});
		$display("test pll fields done");
		for (int r = 0; r < 3; r++)
		begin
			wr(8'h00, 32'h0);
			wr(8'h00, 32'h80 | (32'(r) << 1) | 32'h30);
			measure(1'b0, tbl[r]);
		end
		$display("test ratios done");
		wr(8'h00, 32'h0);
		wr(8'h0C, 32'h100);
		wr(8'h00, 32'h1);
		repeat (8) @(posedge aclk);
		check_word({30'h0, root, ppwr}, 32'h3);
		wr(8'h00, 32'h81);
		measure(1'b1, 256);
		wr(8'h00, 32'h0);
		repeat (8) @(posedge aclk);
		check_word({30'h0, root, ppwr}, 32'h0);
		$display("test pll root done");
		test_done();
	end
endmodule // codec_clock_and_reset_gen_bench
`default_nettype wire
